// >>> rtl/msg_header_flags_status.sv
// Request header capture and reply header flags, error number and byte stream
`timescale 1ns/1ps
module msg_header_flags_status (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Incoming header bytes
  input wire logic rx_valid_i,
  input wire logic rx_first_i,
  input wire logic [7:0] rx_byte_i,
  // Verdict on the received message
  input wire logic done_i,
  input wire logic is_query_i,
  input wire logic type_bad_i,
  input wire logic chk_bad_i,
  input wire logic too_large_i,
  input wire logic len_bad_i,
  input wire logic exc_i,
  input wire logic [15:0] exc_code_i,
  // Outgoing reply header bytes
  output logic tx_valid_o,
  output logic tx_last_o,
  output logic [7:0] tx_byte_o,
  input wire logic tx_ready_i,
  // Status
  output logic busy_o,
  output logic [15:0] flags_o,
  output logic [15:0] err_o,
  output logic [15:0] rx_version_o,
  output logic rx_ack_req_o
);
  import hdr_pkg::*;

  hdr_state_t s_reg;
  hdr_state_t s_next;

  logic [15:0] rx_start;
  logic [15:0] rx_version;
  logic [15:0] rx_flags;
  logic [31:0] rx_type;
  logic proto_bad;
  logic nack;
  logic [15:0] code;
  logic [15:0] new_flags;
  logic want_reply;
  logic [3:0] wr_idx;
  logic rx_take;
  logic [HDR_BYTES-1:0] lane_we;
  logic hdr_full;
  logic [15:0] reply_err;
  logic [HDR_BITS-1:0] reply_hdr;
  logic [3:0] tx_next_idx;

  // Byte at a header index; fields are stored little-endian in the vector
  function automatic logic [7:0] hdr_byte(input logic [HDR_BITS-1:0] hdr,
                                          input logic [3:0] idx);
    hdr_byte = hdr[{idx, 3'h0} +: 8];
  endfunction

  // Word at a byte offset, low byte at the lower offset
  function automatic logic [15:0] hdr_word(input logic [HDR_BITS-1:0] hdr,
                                           input logic [3:0] ofs);
    hdr_word = hdr[{ofs, 3'h0} +: 16];
  endfunction

  // Error word of a reply; nonzero only beside the rejection or exception flag
  function automatic logic [15:0] reply_code(input logic rejected,
                                             input logic fault,
                                             input logic [15:0] picked);
    reply_code = (rejected || fault) ? picked : ERR_SUCCESS;
  endfunction

  assign rx_start = hdr_word(s_reg.rx_hdr, OFS_START);
  assign rx_version = hdr_word(s_reg.rx_hdr, OFS_VERSION);
  assign rx_flags = hdr_word(s_reg.rx_hdr, OFS_FLAGS);
  assign rx_type = s_reg.rx_hdr[{OFS_TYPE, 3'h0} +: 32];

  // Header complete only when every header byte has arrived
  assign hdr_full = (s_reg.rx_idx == HDR_BYTES);

  // A short header or a wrong start pattern is a protocol fault
  assign proto_bad = (rx_start != START_PATTERN) || !hdr_full;

  err_select u_err_select (
    .proto_bad_i(proto_bad),
    .type_bad_i(type_bad_i),
    .chk_bad_i(chk_bad_i),
    .too_large_i(too_large_i),
    .len_bad_i(len_bad_i),
    .exc_i(exc_i),
    .exc_code_i(exc_code_i),
    .nack_o(nack),
    .code_o(code)
  );

  // Only bit 2 of the received flags is read; the rest are ignored
  always_comb begin
    new_flags = FLAGS_CLEAR;
    new_flags[FLAG_RESPONSE] = is_query_i & ~nack;
    new_flags[FLAG_ACK] = rx_flags[FLAG_ACK_REQ] & ~nack;
    new_flags[FLAG_NACK] = nack;
    new_flags[FLAG_EXCEPTION] = exc_i & ~nack;
    new_flags[FLAG_DEPRECATED] = rx_version < DEPRECATE_BELOW;
  end

  // Commands without an acknowledgement request get no reply unless rejected
  assign want_reply = is_query_i | rx_flags[FLAG_ACK_REQ] | nack;

  assign wr_idx = rx_first_i ? 4'h0 : s_reg.rx_idx;
  assign rx_take = rx_valid_i && (wr_idx < HDR_BYTES);

  // One write strobe per header byte lane
  for (genvar b = 0; b < HDR_BYTES; b++) begin : g_lane
    assign lane_we[b] = rx_take && (wr_idx == 4'(b));
  end

  assign reply_err = reply_code(nack, exc_i, code);
  // Next reply byte index; the last byte ends the reply before it wraps
  assign tx_next_idx = s_reg.tx_idx + 4'h1;

  // Reply header image, latched whole when the verdict is taken
  always_comb begin
    reply_hdr = '0;
    reply_hdr[{OFS_START, 3'h0} +: 16] = START_PATTERN;
    reply_hdr[{OFS_VERSION, 3'h0} +: 16] = DEVICE_VERSION;
    reply_hdr[{OFS_FLAGS, 3'h0} +: 16] = new_flags;
    reply_hdr[{OFS_ERROR, 3'h0} +: 16] = reply_err;
    reply_hdr[{OFS_TYPE, 3'h0} +: 32] = rx_type;
  end

  always_comb begin
    s_next = s_reg;
    case (s_reg.state)
      ST_IDLE: begin
        // Bytes past the header are not needed and are dropped
        for (int b = 0; b < HDR_BYTES; b++) begin
          if (lane_we[b]) begin
            s_next.rx_hdr[b*8 +: 8] = rx_byte_i;
          end
        end
        if (rx_take) begin
          s_next.rx_idx = wr_idx + 4'h1;
        end else if (rx_valid_i && rx_first_i) begin
          s_next.rx_idx = 4'h0;
        end
        if (done_i) begin
          s_next.flags = new_flags;
          // Error stays zero unless a rejection or exception is flagged
          s_next.err = reply_err;
          s_next.tx_hdr = reply_hdr;
          s_next.rx_idx = 4'h0;
          if (want_reply) begin
            s_next.state = ST_SEND;
            s_next.tx_idx = 4'h0;
            s_next.tx_valid = 1'b1;
            s_next.tx_byte = START_PATTERN[7:0];
          end
        end
      end
      ST_SEND: begin
        // Incoming bytes are refused here so the echoed fields stay stable
        if (tx_ready_i) begin
          if (s_reg.tx_idx == HDR_LAST) begin
            s_next.state = ST_IDLE;
            s_next.tx_valid = 1'b0;
            s_next.tx_idx = 4'h0;
          end else begin
            s_next.tx_idx = tx_next_idx;
            s_next.tx_byte = hdr_byte(s_reg.tx_hdr, tx_next_idx);
          end
        end
      end
      default: begin
        s_next.state = ST_IDLE;
        s_next.tx_valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg.state <= ST_IDLE;
      s_reg.rx_idx <= 4'h0;
      s_reg.rx_hdr <= '0;
      s_reg.tx_hdr <= '0;
      s_reg.tx_idx <= 4'h0;
      s_reg.tx_valid <= 1'b0;
      s_reg.tx_byte <= 8'h00;
      s_reg.flags <= FLAGS_CLEAR;
      s_reg.err <= ERR_SUCCESS;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tx_valid_o = s_reg.tx_valid;
  assign tx_last_o = s_reg.tx_valid && (s_reg.tx_idx == HDR_LAST);
  assign tx_byte_o = s_reg.tx_byte;
  assign busy_o = (s_reg.state == ST_SEND);
  assign flags_o = s_reg.flags;
  assign err_o = s_reg.err;
  assign rx_version_o = rx_version;
  assign rx_ack_req_o = rx_flags[FLAG_ACK_REQ];

endmodule

// >>> include/hdr_pkg.sv
// Constants and types for the message header flags and error-number logic
package hdr_pkg;

  // Header layout, byte offsets within the header
  localparam logic [3:0] OFS_START = 4'h0;
  localparam logic [3:0] OFS_VERSION = 4'h2;
  localparam logic [3:0] OFS_FLAGS = 4'h4;
  localparam logic [3:0] OFS_ERROR = 4'h6;
  localparam logic [3:0] OFS_TYPE = 4'h8;
  localparam logic [3:0] HDR_BYTES = 4'hC;
  localparam logic [3:0] HDR_LAST = 4'hB;
  localparam int HDR_BITS = 96;

  // Fixed header values
  localparam logic [15:0] START_PATTERN = 16'hC1C0;
  localparam logic [15:0] DEPRECATE_BELOW = 16'h1100;
  // Version this device reports; value is arbitrary
  localparam logic [15:0] DEVICE_VERSION = 16'h1100;

  // Flag bit positions
  localparam int FLAG_RESPONSE = 0;
  localparam int FLAG_ACK = 1;
  localparam int FLAG_ACK_REQ = 2;
  localparam int FLAG_NACK = 3;
  localparam int FLAG_EXCEPTION = 4;
  localparam int FLAG_DEPRECATED = 5;
  localparam logic [15:0] FLAGS_CLEAR = 16'h0000;

  // Error numbers
  localparam logic [15:0] ERR_SUCCESS = 16'h0000;
  localparam logic [15:0] ERR_PROTOCOL = 16'h0001;
  localparam logic [15:0] ERR_UNKNOWN_TYPE = 16'h0002;
  localparam logic [15:0] ERR_CHECKSUM = 16'h0003;
  localparam logic [15:0] ERR_TOO_LARGE = 16'h0004;
  localparam logic [15:0] ERR_LENGTH = 16'h0005;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_SEND = 2'h2
  } state_t;

  typedef struct packed {
    state_t state;
    logic [3:0] rx_idx;
    logic [HDR_BITS-1:0] rx_hdr;
    logic [HDR_BITS-1:0] tx_hdr;
    logic [3:0] tx_idx;
    logic tx_valid;
    logic [7:0] tx_byte;
    logic [15:0] flags;
    logic [15:0] err;
  } hdr_state_t;

endpackage

// >>> rtl/err_select.sv
// Picks the single error number and the rejection decision for one reply
`timescale 1ns/1ps
module err_select (
  // Detected faults
  input wire logic proto_bad_i,
  input wire logic type_bad_i,
  input wire logic chk_bad_i,
  input wire logic too_large_i,
  input wire logic len_bad_i,
  input wire logic exc_i,
  input wire logic [15:0] exc_code_i,
  // Decision
  output logic nack_o,
  output logic [15:0] code_o
);
  import hdr_pkg::*;

  // Fixed priority: the most basic fault wins, so one code is reported
  always_comb begin
    nack_o = proto_bad_i | type_bad_i | chk_bad_i | too_large_i | len_bad_i;
    code_o = ERR_SUCCESS;
    if (proto_bad_i) begin
      code_o = ERR_PROTOCOL;
    end else if (type_bad_i) begin
      code_o = ERR_UNKNOWN_TYPE;
    end else if (chk_bad_i) begin
      code_o = ERR_CHECKSUM;
    end else if (too_large_i) begin
      code_o = ERR_TOO_LARGE;
    end else if (len_bad_i) begin
      code_o = ERR_LENGTH;
    end else if (exc_i) begin
      code_o = exc_code_i;
    end
  end

endmodule

// >>> verif/host_model.sv
// Host side reply sink that stalls at random
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic clk_i,
  // Reply stream
  output logic tx_ready_o
);
  // Ready changes just after each edge; mixes prompt and slow takes
  initial begin
    tx_ready_o = 1'b0;
    forever begin
      @(posedge clk_i);
      #1 tx_ready_o = ($urandom % 3) != 0;
    end
  end
endmodule

// >>> verif/msg_header_flags_status_asserts.sv
// Checker for reply flags, error number and reply stream
`timescale 1ns/1ps
module msg_header_flags_status_asserts
  import hdr_pkg::*;
(
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic done_i,
  input wire logic is_query_i,
  input wire logic busy_o,
  input wire logic tx_valid_o,
  input wire logic tx_last_o,
  input wire logic tx_ready_i,
  input wire logic [7:0] tx_byte_o,
  input wire logic [15:0] flags_o,
  input wire logic [15:0] err_o,
  input wire logic [15:0] rx_version_o,
  input wire logic rx_ack_req_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence verdict_s;
    done_i && !busy_o;
  endsequence
  sequence start_s;
    tx_valid_o && busy_o && tx_byte_o == 8'hC0;
  endsequence
  reply_start_a: assert property (verdict_s ##0 is_query_i |=> start_s)
    else $error("reply not started");
  ack_gate_a: assert property (verdict_s |=>
    flags_o[FLAG_ACK] == ($past(rx_ack_req_o) && !flags_o[FLAG_NACK])) else $error("ack bit");
  old_version_a: assert property (verdict_s |=>
    flags_o[FLAG_DEPRECATED] == ($past(rx_version_o) < DEPRECATE_BELOW)) else $error("old bit");
  err_zero_a: assert property (err_o != ERR_SUCCESS |->
    flags_o[FLAG_NACK] || flags_o[FLAG_EXCEPTION]) else $error("error without flag");
  nack_code_a: assert property (flags_o[FLAG_NACK] |->
    err_o inside {[ERR_PROTOCOL:ERR_LENGTH]} && !flags_o[FLAG_RESPONSE]) else $error("nack");
  upper_zero_a: assert property (flags_o[15:6] == 10'h000)
    else $error("upper flags set");
  verdict_frozen_a: assert property (busy_o |=> $stable(flags_o) && $stable(err_o))
    else $error("verdict changed");
  last_byte_a: assert property (tx_valid_o && tx_last_o && tx_ready_i |=>
    !tx_valid_o && !busy_o) else $error("no stop after last");
  stall_hold_a: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_byte_o)) else $error("byte dropped");
endmodule
bind msg_header_flags_status msg_header_flags_status_asserts msg_header_flags_status_asserts_i (
  .clk_i, .rst_i, .done_i, .is_query_i, .busy_o, .tx_valid_o, .tx_last_o, .tx_ready_i,
  .tx_byte_o, .flags_o, .err_o, .rx_version_o, .rx_ack_req_o);

// >>> verif/msg_header_flags_status_tb_top.sv
// Bench: sends request headers and checks every reply byte
`timescale 1ns/1ps
module msg_header_flags_status_tb_top;
  import hdr_pkg::*;
  logic clk_i, rst_i, rx_valid_i, rx_first_i, done_i, is_query_i, exc_i, tx_ready_i;
  logic type_bad_i, chk_bad_i, too_large_i, len_bad_i, tx_valid_o, tx_last_o, busy_o;
  logic rx_ack_req_o;
  logic [7:0] rx_byte_i, tx_byte_o;
  logic [15:0] exc_code_i, flags_o, err_o, rx_version_o;
  logic [7:0] exp_q[$];
  logic [8:0] want;
  logic [7:0] hb[12];
  int mismatches, check_count, i;
  msg_header_flags_status msg_header_flags_status_i (.clk_i, .rst_i, .rx_valid_i, .rx_first_i,
    .rx_byte_i, .done_i, .is_query_i, .type_bad_i, .chk_bad_i, .too_large_i, .len_bad_i, .exc_i,
    .exc_code_i, .tx_valid_o, .tx_last_o, .tx_byte_o, .tx_ready_i, .busy_o, .flags_o, .err_o,
    .rx_version_o, .rx_ack_req_o);
  host_model host_model_i (.clk_i, .tx_ready_o(tx_ready_i));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic test_done();
    if (mismatches == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // f: exception, length, size, checksum, type, reversed start; n: bytes sent
  task automatic msg(input logic [5:0] f, input logic q, input logic a, input int n);
    logic [15:0] ver, fl, er;
    logic nk;
    ver = 16'($urandom);
    fl = 16'($urandom);
    fl[2] = a;
    hb[0] = f[0] ? 8'hC1 : 8'hC0;
    hb[1] = f[0] ? 8'hC0 : 8'hC1;
    {hb[3], hb[2], hb[5], hb[4]} = {ver, fl};
    for (int k = 6; k < n; k++) hb[k] = 8'($urandom);
    for (int k = 0; k < n; k++) begin
      @(posedge clk_i);
      #1 {rx_valid_i, rx_first_i, rx_byte_i} = {1'b1, k == 0, hb[k]};
    end
    @(posedge clk_i);
    #1 {rx_valid_i, done_i, is_query_i, exc_i, len_bad_i} = {2'b01, q, f[5:4]};
    {too_large_i, chk_bad_i, type_bad_i, exc_code_i} = {f[3:1], 16'($urandom)};
    nk = f[0] || n < 12 || |f[4:1];
    er = (f[0] || n < 12) ? ERR_PROTOCOL : f[1] ? ERR_UNKNOWN_TYPE : f[2] ? ERR_CHECKSUM :
      f[3] ? ERR_TOO_LARGE : f[4] ? ERR_LENGTH : f[5] ? exc_code_i : ERR_SUCCESS;
    fl = {10'h000, ver < DEPRECATE_BELOW, f[5] && !nk, nk, 1'b0, a && !nk, q && !nk};
    if (q || a || nk) begin
      exp_q = {exp_q, 8'hC0, 8'hC1, DEVICE_VERSION[7:0], DEVICE_VERSION[15:8]};
      exp_q = {exp_q, fl[7:0], fl[15:8], er[7:0], er[15:8], hb[8], hb[9], hb[10], hb[11]};
    end
    @(posedge clk_i);
    #1 done_i = 1'b0;
    check_count++;
    if ({flags_o, err_o, rx_version_o, rx_ack_req_o, busy_o} !==
        {fl, er, ver, a, q || a || nk}) begin
      mismatches++;
      $display("wrong value verdict expected %h seen %h", {fl, er, ver, a, q || a || nk},
        {flags_o, err_o, rx_version_o, rx_ack_req_o, busy_o});
    end
    repeat (200) begin
      if (busy_o === 1'b0) break;
      @(posedge clk_i);
      #1;
    end
    check_count++;
    if (busy_o !== 1'b0) begin
      mismatches++;
      $display("wrong value busy_o expected 0 seen %b", busy_o);
    end
  endtask
  // Each taken reply byte is matched against the oldest note
  always @(posedge clk_i) begin
    if (!rst_i && tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
      check_count++;
      want = (exp_q.size() > 0) ? {exp_q.size() == 1, exp_q[0]} : 9'h000;
      if (exp_q.size() == 0 || {tx_last_o, tx_byte_o} !== want) begin
        mismatches++;
        $display("wrong value tx_last_o tx_byte_o expected %h seen %h", want,
          {tx_last_o, tx_byte_o});
      end
      if (exp_q.size() > 0) void'(exp_q.pop_front());
    end
  end
  initial begin
    {rx_valid_i, rx_first_i, done_i, is_query_i, exc_i, rx_byte_i} = '0;
    {type_bad_i, chk_bad_i, too_large_i, len_bad_i, exc_code_i, rst_i} = {20'h00000, 1'b1};
    void'($urandom(79296));
    repeat (12) @(posedge clk_i);
    #1 rst_i = 1'b0;
    msg(6'h00, 1'b1, 1'b0, 12);
    msg(6'h00, 1'b0, 1'b0, 12);
    msg(6'h00, 1'b0, 1'b1, 12);
    for (i = 0; i < 6; i++) msg(6'h01 << i, 1'($urandom), 1'($urandom), 12);
    for (i = 0; i < 20; i++) msg(6'($urandom), 1'($urandom), 1'($urandom), 12);
    msg(6'h00, 1'b1, 1'b1, 8);
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 rst_i = 1'b0;
    check_count++;
    if ({flags_o, err_o, rx_version_o, tx_byte_o, tx_valid_o, tx_last_o, busy_o,
         rx_ack_req_o} !== '0) begin
      mismatches++;
      $display("wrong value reset outputs expected 0 seen %h", {flags_o, err_o, busy_o});
    end
    msg(6'h20, 1'b1, 1'b0, 12);
    repeat (4) @(posedge clk_i);
    check_count++;
    if (exp_q.size() != 0) begin
      mismatches++;
      $display("wrong value exp_q.size expected 0 seen %0d", exp_q.size());
    end
    test_done();
  end
  initial begin
    #200000;
    mismatches++;
    test_done();
  end
endmodule
